/* File: common/vrct_regs.svh */
`ifndef VRCT_REGS_SVH
`define VRCT_REGS_SVH
// ==========================================
// Timing
`define VRCT_CLK_NS          50
`define VRCT_MS_NS           1000000
`define VRCT_START_MS        1000
`define VRCT_DIR_MS          10
`define VRCT_CI_MS           10
`define VRCT_SUSP_MS         250
`define VRCT_RESUME_MS       250
`define VRCT_SETFREE_MS      250
`define VRCT_RELEASE_MS      50
`define VRCT_DIRWR_HC_MS     250
`define VRCT_DIRWR_XC_MS     500
`define VRCT_CIWR_MS         250
`define VRCT_AVG_SINGLE_MS   100
`define VRCT_AVG_MULTI_MS    150
`define VRCT_PEAK_MS         750
`define VRCT_SMALL_READ_MS   20
`define VRCT_WINDOW          8
// ==========================================
// Register offsets
`define VRCT_CTRL_OFS        8'h00
`define VRCT_STATUS_OFS      8'h04
`define VRCT_SLOTS_OFS       8'h08
`define VRCT_FATSUM_OFS      8'h0C
`define VRCT_SREAD_OFS       8'h10
`define VRCT_SUREAD_OFS      8'h14
`define VRCT_SUWRITE_OFS     8'h18
// ==========================================
// Fields and reset values
`define VRCT_CTRL_LARGE      0
`define VRCT_CTRL_MODE_LSB   1
`define VRCT_CTRL_CLASS_LSB  5
`define VRCT_CTRL_CLEAR      8
`define VRCT_CTRL_RST        8'h00
`define VRCT_ST_MULTI        0
`define VRCT_ST_STARTED      1
`define VRCT_ST_AVG_VIOL     2
`define VRCT_ST_PEAK_VIOL    3
`define VRCT_ST_READ_VIOL    4
`define VRCT_ST_PR_OK        5
`define VRCT_ST_APPLIES      6
`define VRCT_ST_MODE_OK      7
`define VRCT_ST_BUSY         8
`define VRCT_ST_SUPP_LSB     16
`endif

/* File: common/vrct_pkg.sv */
package vrct_pkg;
	typedef enum logic [3:0] {
		VRCT_SF_START   = 4'h0,
		VRCT_SF_DIR     = 4'h1,
		VRCT_SF_CI      = 4'h4,
		VRCT_SF_SUSPEND = 4'h5,
		VRCT_SF_RESUME  = 4'h6,
		VRCT_SF_SETFREE = 4'h7,
		VRCT_SF_RELEASE = 4'h8
	} vrct_subfn_e;
	typedef enum logic [3:0] {
		VRCT_BM_DS     = 4'h0,
		VRCT_BM_SDR12  = 4'h1,
		VRCT_BM_HS     = 4'h2,
		VRCT_BM_SDR25  = 4'h3,
		VRCT_BM_SDR50  = 4'h4,
		VRCT_BM_DDR50  = 4'h5,
		VRCT_BM_SDR104 = 4'h6,
		VRCT_BM_FD     = 4'h7,
		VRCT_BM_HD     = 4'h8
	} vrct_bus_e;
	typedef enum logic [2:0] {
		VRCT_CL_NONE = 3'h0,
		VRCT_CL_6    = 3'h1,
		VRCT_CL_10   = 3'h2,
		VRCT_CL_30   = 3'h3,
		VRCT_CL_60   = 3'h4,
		VRCT_CL_90   = 3'h5
	} vrct_class_e;
	typedef enum logic [1:0] {
		VRCT_IDLE   = 2'b00,
		VRCT_CMD    = 2'b01,
		VRCT_WAITWR = 2'b11,
		VRCT_TBLWR  = 2'b10
	} vrct_state_e;
	typedef logic [10:0] vrct_ms_t;
endpackage

/* File: hw/vrct_core.sv */
`timescale 1ns/1ps
`include "vrct_regs.svh"
// Behaviour
// - Read performance not below write performance
// - Sub-unit reads back-to-back only, worst counts
// - Small table read finishes within 20ms
// - Each subfunction busy stays under its limit
// - Table write after update bounded 250/500ms
// - Only set-free busy counts toward write time
// - Claimed class implies every lower class
// - Class met in its mandatory bus modes
// - Default and SDR12 modes carry no guarantee
// - Single-slot average table write at most 100ms
// - Multi-slot average table write at most 150ms
// - No table write busy beyond 750ms
// - One peak write per eight updates
// - Average slides over last eight, all slots
// - Reset single-slot; mode set at start
// - New slot needs another start to apply
// - Only slot one keeps single-slot mode
// - Any slot two..eight gives multi-slot mode
// - Eight directory slots open at once
// - Function command always implemented
// - Code 0000b starts recording, cleans up
// - Decode directory, info, suspend, resume, set-free
// - Assigned slot update answers with error, except slot one or any slot in multi mode after a start
// - Start needs class flag; other fields reserved
module vrct_core #(
	parameter int unsigned TICK_CYCLES = `VRCT_MS_NS / `VRCT_CLK_NS
) (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 arst_n_in,
	// Command path
	input  wire logic                 cmd_valid_in,
	input  wire vrct_pkg::vrct_subfn_e cmd_subfn_in,
	input  wire logic                 cmd_rcflag_in,
	input  wire logic [2:0]           cmd_slot_in,
	input  wire logic                 work_done_in,
	input  wire logic                 wr_prog_start_in,
	input  wire logic                 wr_prog_done_in,
	// Measurement events
	input  wire logic                 su_read_start_in,
	input  wire logic                 su_read_done_in,
	input  wire logic                 su_write_start_in,
	input  wire logic                 su_write_done_in,
	input  wire logic                 other_cmd_in,
	input  wire logic                 fs_read_start_in,
	input  wire logic                 fs_read_done_in,
	// Card answers
	output logic                      resp_valid_out,
	output logic                      resp_error_out,
	output logic                      busy_out,
	output logic                      multi_slot_out,
	output logic                      gc_start_out,
	// AXI4-Lite slave
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	output logic [1:0]                s_axi_bresp,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	input  wire logic [7:0]           s_axi_araddr,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp
);
	import vrct_pkg::*;

	localparam logic [31:0] SMALL_READ_CYC = 32'(`VRCT_SMALL_READ_MS * TICK_CYCLES);
	localparam logic [31:0] TICK_LAST      = 32'(TICK_CYCLES - 1);

	// ==========================================
	// Register file
	logic [7:0]  ctrl_ff;
	logic        clear_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        aw_got_ff;
	logic        w_got_ff;
	logic        wr_en;
	logic [31:0] rd_mux;
	logic        rd_hit;
	logic [31:0] status;

	assign wr_en = aw_got_ff && w_got_ff && !s_axi_bvalid;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			awaddr_ff     <= 8'h00;
			wdata_ff      <= 32'h00000000;
			wstrb_ff      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_ff     <= s_axi_awaddr;
				aw_got_ff     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff     <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
				w_got_ff     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_ff == `VRCT_CTRL_OFS) ? 2'b00 : 2'b10;
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Clear is a one-cycle pulse so sticky flags can re-arm at once
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_ff  <= `VRCT_CTRL_RST;
			clear_ff <= 1'b0;
		end else begin
			clear_ff <= wr_en && (awaddr_ff == `VRCT_CTRL_OFS) && wstrb_ff[1] && wdata_ff[`VRCT_CTRL_CLEAR];
			if (wr_en && (awaddr_ff == `VRCT_CTRL_OFS) && wstrb_ff[0]) begin
				ctrl_ff <= wdata_ff[7:0];
			end
		end
	end

	// ==========================================
	// Bus mode and class support
	vrct_bus_e   bus_mode;
	vrct_class_e rc_class;
	vrct_bus_e   min_mode;
	logic        class_applies;
	logic        mode_ok;
	logic [4:0]  supp_mask;

	assign bus_mode      = vrct_bus_e'(ctrl_ff[`VRCT_CTRL_MODE_LSB +: 4]);
	assign rc_class      = vrct_class_e'(ctrl_ff[`VRCT_CTRL_CLASS_LSB +: 3]);
	assign class_applies = (bus_mode != VRCT_BM_DS) && (bus_mode != VRCT_BM_SDR12);

	always_comb begin
		min_mode = VRCT_BM_HS;
		if (rc_class == VRCT_CL_30) begin
			min_mode = VRCT_BM_SDR50;
		end else if (rc_class == VRCT_CL_60 || rc_class == VRCT_CL_90) begin
			min_mode = VRCT_BM_FD;
		end
	end
	// SDR25 sits below SDR50 in the code order, so no hole for class 30
	assign mode_ok = class_applies && (bus_mode >= min_mode) && (bus_mode <= VRCT_BM_HD);

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_supp
			assign supp_mask[gi] = (3'(gi + 1) <= rc_class);
		end
	endgenerate

	// ==========================================
	// Command decode and busy sequencing
	vrct_state_e state_ff;
	vrct_state_e nxt_state;
	vrct_subfn_e op_ff;
	vrct_ms_t    limit_ff;
	vrct_ms_t    ms_ff;
	logic [31:0] tick_ff;
	logic        assoc_ci_ff;
	logic [7:0]  slot_ff;
	logic        started_ff;
	logic        accept;
	logic        op_end;
	logic        dir_err;

	function automatic vrct_ms_t busy_limit(input vrct_subfn_e sf);
		unique case (sf)
			VRCT_SF_START:   busy_limit = vrct_ms_t'(`VRCT_START_MS);
			VRCT_SF_DIR:     busy_limit = vrct_ms_t'(`VRCT_DIR_MS);
			VRCT_SF_CI:      busy_limit = vrct_ms_t'(`VRCT_CI_MS);
			VRCT_SF_SUSPEND: busy_limit = vrct_ms_t'(`VRCT_SUSP_MS);
			VRCT_SF_RESUME:  busy_limit = vrct_ms_t'(`VRCT_RESUME_MS);
			VRCT_SF_SETFREE: busy_limit = vrct_ms_t'(`VRCT_SETFREE_MS);
			VRCT_SF_RELEASE: busy_limit = vrct_ms_t'(`VRCT_RELEASE_MS);
			default:         busy_limit = vrct_ms_t'(1);
		endcase
	endfunction

	// Only class-flagged commands act; legacy use is answered and ignored
	assign accept = cmd_valid_in && cmd_rcflag_in && (state_ff == VRCT_IDLE || state_ff == VRCT_WAITWR);
	assign op_end = work_done_in || (ms_ff >= limit_ff);
	// After a start, reassigning is legal: slot 1 in single mode, any slot in multi mode
	assign dir_err = slot_ff[cmd_slot_in] &&
		!(started_ff && (multi_slot_out || cmd_slot_in == 3'd0));

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			VRCT_IDLE: begin
				if (accept) begin
					nxt_state = VRCT_CMD;
				end
			end
			VRCT_CMD: begin
				if (op_end) begin
					nxt_state = (op_ff == VRCT_SF_DIR || op_ff == VRCT_SF_CI) ? VRCT_WAITWR : VRCT_IDLE;
				end
			end
			VRCT_WAITWR: begin
				if (accept) begin
					nxt_state = VRCT_CMD;
				end else if (wr_prog_start_in) begin
					nxt_state = VRCT_TBLWR;
				end
			end
			VRCT_TBLWR: begin
				if (wr_prog_done_in || ms_ff >= limit_ff) begin
					nxt_state = VRCT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_ff    <= VRCT_IDLE;
			op_ff       <= VRCT_SF_START;
			limit_ff    <= vrct_ms_t'(0);
			assoc_ci_ff <= 1'b0;
			busy_out    <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			busy_out <= (nxt_state == VRCT_CMD) || (nxt_state == VRCT_TBLWR);
			if (accept) begin
				op_ff       <= cmd_subfn_in;
				limit_ff    <= busy_limit(cmd_subfn_in);
				assoc_ci_ff <= (cmd_subfn_in == VRCT_SF_CI);
			end else if (state_ff == VRCT_WAITWR && wr_prog_start_in) begin
				limit_ff <= assoc_ci_ff ? vrct_ms_t'(`VRCT_CIWR_MS) :
					ctrl_ff[`VRCT_CTRL_LARGE] ? vrct_ms_t'(`VRCT_DIRWR_XC_MS) : vrct_ms_t'(`VRCT_DIRWR_HC_MS);
			end
		end
	end

	// Millisecond timebase restarts at every new busy phase
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tick_ff <= 32'h00000000;
			ms_ff   <= vrct_ms_t'(0);
		end else if (accept || (state_ff == VRCT_WAITWR && wr_prog_start_in)) begin
			tick_ff <= 32'h00000000;
			ms_ff   <= vrct_ms_t'(0);
		end else if (tick_ff == TICK_LAST) begin
			tick_ff <= 32'h00000000;
			ms_ff   <= ms_ff + vrct_ms_t'(1);
		end else begin
			tick_ff <= tick_ff + 32'h00000001;
		end
	end

	// Slot vector and slot mode
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			slot_ff        <= 8'h00;
			started_ff     <= 1'b0;
			multi_slot_out <= 1'b0;
			resp_valid_out <= 1'b0;
			resp_error_out <= 1'b0;
			gc_start_out   <= 1'b0;
		end else begin
			resp_valid_out <= cmd_valid_in && (state_ff == VRCT_IDLE || state_ff == VRCT_WAITWR);
			resp_error_out <= accept && (cmd_subfn_in == VRCT_SF_DIR) && dir_err;
			gc_start_out   <= accept && (cmd_subfn_in == VRCT_SF_START);
			if (accept) begin
				unique case (cmd_subfn_in)
					VRCT_SF_START: begin
						started_ff     <= 1'b1;
						multi_slot_out <= |slot_ff[7:1];
					end
					VRCT_SF_DIR: begin
						if (!dir_err) begin
							slot_ff[cmd_slot_in] <= 1'b1;
						end
					end
					VRCT_SF_RELEASE: slot_ff[cmd_slot_in] <= 1'b0;
					VRCT_SF_SUSPEND: slot_ff <= 8'h00;
					default: ;
				endcase
			end
		end
	end

	// ==========================================
	// Table write time window
	vrct_ms_t    dur_ff [`VRCT_WINDOW];
	logic [7:0]  peak_hit;
	logic [13:0] win_sum;
	logic [13:0] avg_thresh;
	logic        tbl_done;
	logic        avg_viol_ff;
	logic        peak_viol_ff;

	assign tbl_done = (state_ff == VRCT_TBLWR) && (nxt_state == VRCT_IDLE);

	// Shared window across all slots, newest entry at index 0
	generate
		for (gi = 0; gi < `VRCT_WINDOW; gi++) begin : g_win
			always_ff @(posedge clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					dur_ff[gi] <= vrct_ms_t'(0);
				end else if (tbl_done) begin
					dur_ff[gi] <= (gi == 0) ? ms_ff : dur_ff[(gi == 0) ? 0 : gi - 1];
				end
			end
			assign peak_hit[gi] = (dur_ff[gi] >= vrct_ms_t'(`VRCT_PEAK_MS));
		end
	endgenerate

	always_comb begin
		win_sum = 14'h0000;
		for (int i = 0; i < `VRCT_WINDOW; i++) begin
			win_sum = win_sum + 14'(dur_ff[i]);
		end
	end
	assign avg_thresh = multi_slot_out ? 14'(`VRCT_AVG_MULTI_MS * `VRCT_WINDOW) :
		14'(`VRCT_AVG_SINGLE_MS * `VRCT_WINDOW);

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			avg_viol_ff  <= 1'b0;
			peak_viol_ff <= 1'b0;
		end else begin
			avg_viol_ff  <= (win_sum > avg_thresh) || (avg_viol_ff && !clear_ff);
			peak_viol_ff <= ($countones(peak_hit) > 1) || (peak_viol_ff && !clear_ff);
		end
	end

	// ==========================================
	// Read and write performance measurement
	logic [31:0] fsr_cnt_ff, fsr_worst_ff;
	logic        fsr_act_ff, read_viol_ff;
	logic [31:0] sur_cnt_ff, sur_worst_ff, suw_cnt_ff, suw_worst_ff;
	logic        sur_act_ff, sur_ok_ff, suw_act_ff;
	logic        other_busy, setfree_busy;

	assign setfree_busy = (state_ff == VRCT_CMD) && (op_ff == VRCT_SF_SETFREE);
	assign other_busy   = busy_out && !setfree_busy;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fsr_cnt_ff   <= 32'h00000000;
			fsr_worst_ff <= 32'h00000000;
			fsr_act_ff   <= 1'b0;
			read_viol_ff <= 1'b0;
		end else begin
			read_viol_ff <= (fs_read_done_in && fsr_act_ff && fsr_cnt_ff > SMALL_READ_CYC) ||
				(read_viol_ff && !clear_ff);
			if (fs_read_start_in) begin
				fsr_act_ff <= 1'b1;
				fsr_cnt_ff <= 32'h00000000;
			end else if (fs_read_done_in && fsr_act_ff) begin
				fsr_act_ff <= 1'b0;
				if (fsr_cnt_ff > fsr_worst_ff) begin
					fsr_worst_ff <= fsr_cnt_ff;
				end
			end else if (fsr_act_ff) begin
				fsr_cnt_ff <= fsr_cnt_ff + 32'h00000001;
			end
		end
	end

	// Interleaved commands spoil the running sub-unit read
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sur_cnt_ff   <= 32'h00000000;
			sur_worst_ff <= 32'h00000000;
			sur_act_ff   <= 1'b0;
			sur_ok_ff    <= 1'b0;
		end else begin
			if (su_read_start_in) begin
				sur_act_ff <= 1'b1;
				sur_ok_ff  <= 1'b1;
				sur_cnt_ff <= 32'h00000000;
			end else if (su_read_done_in && sur_act_ff) begin
				sur_act_ff <= 1'b0;
				if (sur_ok_ff && sur_cnt_ff > sur_worst_ff) begin
					sur_worst_ff <= sur_cnt_ff;
				end
			end else if (sur_act_ff) begin
				sur_cnt_ff <= sur_cnt_ff + 32'h00000001;
				if (other_cmd_in) begin
					sur_ok_ff <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			suw_cnt_ff   <= 32'h00000000;
			suw_worst_ff <= 32'h00000000;
			suw_act_ff   <= 1'b0;
		end else begin
			if (su_write_start_in) begin
				suw_act_ff <= 1'b1;
			end else if (su_write_done_in && suw_act_ff) begin
				suw_act_ff <= 1'b0;
				suw_cnt_ff <= 32'h00000000;
				if (suw_cnt_ff > suw_worst_ff) begin
					suw_worst_ff <= suw_cnt_ff;
				end
			end else if ((suw_act_ff && !other_busy) || setfree_busy) begin
				suw_cnt_ff <= suw_cnt_ff + 32'h00000001;
			end
		end
	end

	// ==========================================
	// Read channel
	assign status = {11'h000, supp_mask, 7'h00, busy_out, mode_ok, class_applies,
		(sur_worst_ff <= suw_worst_ff), read_viol_ff, peak_viol_ff, avg_viol_ff, started_ff, multi_slot_out};

	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`VRCT_CTRL_OFS:    rd_mux = {24'h000000, ctrl_ff};
			`VRCT_STATUS_OFS:  rd_mux = status;
			`VRCT_SLOTS_OFS:   rd_mux = {24'h000000, slot_ff};
			`VRCT_FATSUM_OFS:  rd_mux = {18'h00000, win_sum};
			`VRCT_SREAD_OFS:   rd_mux = fsr_worst_ff;
			`VRCT_SUREAD_OFS:  rd_mux = sur_worst_ff;
			`VRCT_SUWRITE_OFS: rd_mux = suw_worst_ff;
			default: begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_start_acc;
		accept && cmd_subfn_in == VRCT_SF_START;
	endsequence

	a_busy_bounded: assert property ((state_ff == VRCT_CMD) |-> ms_ff <= limit_ff)
		else $error("command busy ran past its limit");
	a_tblwr_bounded: assert property ((state_ff == VRCT_TBLWR) |-> ms_ff <= vrct_ms_t'(`VRCT_DIRWR_XC_MS))
		else $error("table write busy ran past its limit");
	a_start_mode: assert property (s_start_acc |=> multi_slot_out == |$past(slot_ff[7:1]) && gc_start_out)
		else $error("start did not set slot mode or cleanup");
	a_mode_stable: assert property (!(accept && cmd_subfn_in == VRCT_SF_START) |=> $stable(multi_slot_out))
		else $error("slot mode changed without start");
	a_dir_error: assert property (accept && cmd_subfn_in == VRCT_SF_DIR && slot_ff[cmd_slot_in] && !started_ff
		|=> resp_valid_out && resp_error_out)
		else $error("assigned slot update not flagged");
	a_avg_flag: assert property (win_sum > avg_thresh |=> avg_viol_ff)
		else $error("average table write overrun not flagged");
	a_peak_flag: assert property ($countones(peak_hit) > 1 |=> peak_viol_ff)
		else $error("second peak write in window not flagged");
	a_read_flag: assert property (fs_read_done_in && fsr_act_ff && fsr_cnt_ff > SMALL_READ_CYC |=> read_viol_ff)
		else $error("slow table read not flagged");
	a_write_excl: assert property (other_busy && !su_write_start_in && !su_write_done_in |=> $stable(suw_cnt_ff))
		else $error("foreign busy counted in write time");
	a_busy_done: assert property ((state_ff == VRCT_CMD) && work_done_in |=> !busy_out || state_ff != VRCT_CMD)
		else $error("busy held after work completed");
endmodule

/* File: verif/vrct_host.sv */
`timescale 1ns/1ps
// ====
// Host side: one function command, only while the card is not busy
module vrct_host (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  arst_n_in,
	// Request from the bench
	input  wire logic                  req_in,
	input  wire vrct_pkg::vrct_subfn_e code_in,
	input  wire logic                  flag_in,
	input  wire logic [2:0]            slot_in,
	input  wire logic                  busy_in,
	// Command lines to the card
	output vrct_pkg::vrct_subfn_e      cmd_subfn_out,
	output logic                       cmd_valid_out,
	output logic                       cmd_rcflag_out,
	output logic [2:0]                 cmd_slot_out
);
	import vrct_pkg::*;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cmd_valid_out <= 1'h0;
			cmd_subfn_out <= VRCT_SF_START;
			cmd_rcflag_out <= 1'h0;
			cmd_slot_out <= 3'h0;
		end else if (req_in && !busy_in && !cmd_valid_out) begin
			cmd_valid_out <= 1'h1;
			cmd_subfn_out <= code_in;
			cmd_rcflag_out <= flag_in;
			cmd_slot_out <= slot_in;
		end else begin
			// Idle lines carry no meaning; toggle so no stale value passes
			cmd_valid_out <= 1'h0;
			cmd_subfn_out <= vrct_subfn_e'(~cmd_subfn_out);
			cmd_rcflag_out <= ~cmd_rcflag_out;
			cmd_slot_out <= ~cmd_slot_out;
		end
	end
endmodule

/* File: verif/video_record_cmd_timing_tb.sv */
`timescale 1ns/1ps
module video_record_cmd_timing_tb;
	import vrct_pkg::*;
	localparam int   TK = 4;
	localparam logic T  = 1'h1;
	localparam logic F  = 1'h0;
	typedef struct {vrct_subfn_e f; logic [2:0] s; logic r, e, m;} vrct_row_s;
	logic        clk_in, arst_n_in, hreq, hflag, hv, hr, wd, wps, awv, wv, bry, arv, rry;
	logic        rv, re, bz, mu, gc, awr, wrd, bv, arr, rvl, oc, wpd;
	vrct_subfn_e hcode, hsub;
	logic [2:0]  hslot, hs;
	logic [5:0]  ms;
	logic [7:0]  awa, ara;
	logic [31:0] wdt, rdt, d;
	logic [1:0]  br, rr, r;
	int          failures, cmp_count;
	vrct_row_s   rows [15] = '{
		'{VRCT_SF_DIR, 3'h0, T, F, F}, '{VRCT_SF_DIR, 3'h0, T, T, F}, '{VRCT_SF_START, 3'h0, T, F, F},
		'{VRCT_SF_DIR, 3'h0, T, F, F}, '{VRCT_SF_DIR, 3'h3, T, F, F}, '{VRCT_SF_DIR, 3'h3, T, T, F},
		'{VRCT_SF_START, 3'h0, T, F, T}, '{VRCT_SF_DIR, 3'h3, T, F, T},
		'{VRCT_SF_CI, 3'h0, T, F, T}, '{VRCT_SF_SETFREE, 3'h0, T, F, T}, '{VRCT_SF_RELEASE, 3'h3, T, F, T},
		'{VRCT_SF_SUSPEND, 3'h0, T, F, T}, '{VRCT_SF_RESUME, 3'h0, T, F, T},
		'{VRCT_SF_START, 3'h0, T, F, F}, '{VRCT_SF_START, 3'h0, F, F, F}};
	vrct_host u_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(hreq), .code_in(hcode), .flag_in(hflag),
		.slot_in(hslot), .busy_in(bz), .cmd_subfn_out(hsub), .cmd_valid_out(hv), .cmd_rcflag_out(hr),
		.cmd_slot_out(hs));
	vrct_core #(.TICK_CYCLES(TK)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(hv),
		.cmd_subfn_in(hsub), .cmd_rcflag_in(hr), .cmd_slot_in(hs), .work_done_in(wd), .wr_prog_start_in(wps),
		.wr_prog_done_in(wpd), .su_read_start_in(ms[0]), .su_read_done_in(ms[1]), .su_write_start_in(ms[2]),
		.su_write_done_in(ms[3]), .other_cmd_in(oc), .fs_read_start_in(ms[4]), .fs_read_done_in(ms[5]),
		.resp_valid_out(rv), .resp_error_out(re), .busy_out(bz), .multi_slot_out(mu), .gc_start_out(gc),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_wdata(wdt), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rvl),
		.s_axi_rready(rry), .s_axi_rdata(rdt), .s_axi_rresp(rr));
	// ====
	// Helpers
	task automatic tk();
		@(posedge clk_in);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input vrct_subfn_e f, input logic [2:0] s, input logic fl);
		hreq <= T;
		hcode <= f;
		hslot <= s;
		hflag <= fl;
		do tk(); while (hv !== T);
		hreq <= F;
		tk();
		chk("resp", T, rv);
		chk("gc", f == VRCT_SF_START && fl, gc);
		chk("busy", fl, bz);
	endtask
	// Optional write start, then busy length against a limit in ms
	task automatic blen(input int lim, input logic w, input string n);
		int k;
		k = 0;
		if (w) begin
			wps <= T;
			tk();
			wps <= F;
			tk();
		end
		while (bz === T && k < 5000) begin
			tk();
			k++;
		end
		chk(n, T, k >= lim * TK - 2 && k <= lim * TK + 2);
	endtask
	task automatic frame(input int i, input int n);
		ms[2*i] <= T;
		tk();
		ms[2*i] <= F;
		repeat (n) tk();
		ms[2*i+1] <= T;
		tk();
		ms[2*i+1] <= F;
		tk();
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic ad, dd;
		ad = F;
		dd = F;
		awv <= T;
		awa <= a;
		wv <= T;
		wdt <= v;
		bry <= T;
		while (!(ad && dd)) begin
			tk();
			if (!ad && awr) begin
				ad = T;
				awv <= F;
			end
			if (!dd && wrd) begin
				dd = T;
				wv <= F;
			end
		end
		do tk(); while (bv !== T);
		r = br;
		bry <= F;
	endtask
	task automatic axr(input logic [7:0] a);
		arv <= T;
		ara <= a;
		rry <= T;
		do tk(); while (arr !== T);
		arv <= F;
		do tk(); while (rvl !== T);
		d = rdt;
		r = rr;
		rry <= F;
		tk();
	endtask
	// ====
	// Clock, watchdog, tests
	initial begin
		clk_in = F;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		#(30000 * 50);
		failures++;
		results();
	end
	initial begin
		{hreq, hflag, wd, wps, awv, wv, bry, arv, rry, oc, wpd} = '0;
		{hslot, ms, awa, ara, wdt} = '0;
		hcode = VRCT_SF_START;
		failures = 0;
		cmp_count = 0;
		arst_n_in = F;
		repeat (12) tk();
		chk("reset outs", 6'h07, {bz, mu, rv, awr, wrd, arr});
		arst_n_in <= T;
		tk();
		foreach (rows[i]) begin
			cmd(rows[i].f, rows[i].s, rows[i].r);
			chk("err", rows[i].e, re);
			wd <= T;
			tk();
			wd <= F;
			repeat (3) tk();
			chk("idle", F, bz);
			chk("mode", rows[i].m, mu);
			$display("row %0d done", i);
		end
		cmd(VRCT_SF_DIR, 3'h6, T);
		blen(10, F, "dir limit");
		blen(250, T, "dir write limit");
		axw(8'h00, 32'h25);
		chk("ctrl bresp", 2'h0, r);
		cmd(VRCT_SF_DIR, 3'h2, T);
		blen(10, F, "dir limit 2");
		blen(500, T, "large write limit");
		$display("busy limits done");
		axr(8'h04);
		chk("class in hs", 2'h3, d[7:6]);
		chk("supp", 5'h01, d[20:16]);
		axw(8'h00, 32'h20);
		axr(8'h04);
		chk("class in ds", F, d[6]);
		axw(8'h04, 32'h0);
		chk("ro bresp", 2'h2, r);
		axr(8'h40);
		chk("unmapped resp", 2'h2, r);
		chk("unmapped data", 32'h0, d);
		$display("registers done");
		frame(1, 20);
		frame(0, 10);
		frame(2, 100);
		axr(8'h04);
		chk("measures", 2'h3, d[5:4]);
		// Interleaved command must leave the worst read untouched
		oc <= T;
		frame(0, 40);
		oc <= F;
		axr(8'h14);
		chk("su read spoiled", 32'h0000000A, d);
		cmd(VRCT_SF_CI, 3'h0, T);
		wd <= T;
		tk();
		wd <= F;
		tk();
		wps <= T;
		tk();
		wps <= F;
		repeat (40) tk();
		chk("tbl busy", T, bz);
		wpd <= T;
		tk();
		wpd <= F;
		tk();
		chk("tbl done", F, bz);
		axr(8'h0C);
		chk("window sum", 32'h000002F8, d);
		chk("host budget", T, d <= 32'h00000320);
		$display("tables done");
		// Second reset mid-run must drop sticky flags and controls
		arst_n_in <= F;
		tk();
		arst_n_in <= T;
		axr(8'h04);
		chk("status reset", 2'h0, {d[4], d[0]});
		axr(8'h00);
		chk("ctrl reset", 32'h0, d);
		$display("reset done");
		results();
	end
endmodule
